// ### src/spi_pin_baud.sv
// SPI pin configuration, baud generator and byte shifter with APB registers.
// Assumes APB master on pclk; pins pass through an external pad ring.
// Functional notes
// - Master with fault detect off ignores the slave-select pin.
// - Slave mode uses slave-select purely as an input.
// - Master aborts transfer on change of fault enable, pin select, baud.
// - Bidir mode: output enable gates MOSI as master, MISO as slave.
// - Master bidir: change of output enable aborts transfer.
// - Stop-in-wait set halts serial clock during wait mode.
// - Pin select 1 gives single-wire bidir, 0 normal two wires.
// - Master normal: MISO in, MOSI out.
// - Master bidir: MISO unused, MOSI input or input/output.
// - Slave normal: MISO out, MOSI in.
// - Slave bidir: MOSI unused, MISO input or input/output.
// - Baud preselect field sits in bits 6 to 4.
// - Baud exponent field sits in bits 2 to 0.
// - Divisor is (preselect+1) times two to the (exponent+1).
// - Master serial clock is bus clock over divisor.
// - Divisor spans 2 to 2048, every field value legal.
// - Both registers read and write anytime; reserved bits ignore writes.
// - Master with fault detect and select output off sets fault flag when select goes low.
// - Master with fault detect and select output drives select pin.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module spi_pin_baud (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [spi_pin_pkg::ADDR_W-1:0] paddr,
	input  wire logic [spi_pin_pkg::DATA_W-1:0] pwdata,
	output logic      [spi_pin_pkg::DATA_W-1:0] prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         wait_mode,
	input  wire logic                         sck_in,
	output spi_pin_pkg::pin_out_s             sck_out,
	input  wire logic                         mosi_in,
	output spi_pin_pkg::pin_out_s             mosi_out,
	input  wire logic                         miso_in,
	output spi_pin_pkg::pin_out_s             miso_out,
	input  wire logic                         select_in,
	output spi_pin_pkg::pin_out_s             select_out
);
	import spi_pin_pkg::*;

	ctrl_s               ctrl;
	pin_control_s        pin_ctl;
	baud_s               baud;
	xfer_e               state;
	logic [2:0][3:0]     sync;
	logic [3:0]          settled;
	logic                sck_prev;
	logic [HALF_W-1:0]   div_cnt;
	logic [3:0]          edge_cnt;
	logic                sck_level;
	logic [7:0]          shifter;
	logic [7:0]          rx_data;
	logic                sample;
	logic                done_flag;
	logic                fault_flag;
	logic                fault_armed;
	logic [7:0]          rd_byte;
	logic [2:0]          idx;
	logic                mapped;
	logic                setup;
	logic                wr;
	logic                rd;
	logic [7:0]          wbyte;
	pin_control_s        new_pin;
	baud_s               new_baud;
	ctrl_s               new_ctrl;
	logic                master;
	logic                fault_evt;
	logic                cfg_abort;
	logic                abort;
	logic                halted;
	logic                start;
	logic                rx_bit;
	logic                sel_low;
	logic                slave_act;
	logic                sck_rise;
	logic                sck_fall;
	logic                mode_flip;
	logic                master_rise;
	logic                master_done;
	logic                slave_done;
	logic [SAMPLE_LAG-1:0] rise_dly;
	logic [7:0]          rx_shift;
	logic [3:0]          rx_cnt;

	// Half period in bus clocks: (pre+1) << exp
	function automatic logic [HALF_W-1:0] half_period(input baud_s b);
		logic [HALF_W-1:0] m;
		m = {8'h00, b.baud_preselect} + 11'h001;
		return m << b.baud_exponent;
	endfunction

	// A pin counts as changed once stages two and three agree
	function automatic logic [3:0] settle(input logic [3:0] s1,
		input logic [3:0] s2, input logic [3:0] prev);
		return (~(s1 ^ s2) & s2) | ((s1 ^ s2) & prev);
	endfunction

	// APB decode
	assign idx     = paddr[4:2];
	assign mapped  = (paddr[ADDR_W-1:5] == '0) && (paddr[1:0] == 2'h0)
		&& (idx <= IDX_STAT || idx == IDX_DATA);
	assign setup   = psel && !penable;
	assign wr      = psel && penable && pwrite && mapped;
	assign rd      = psel && penable && !pwrite && mapped;
	assign wbyte   = pwdata[7:0];
	assign pready  = psel && penable;
	assign pslverr = psel && penable && !mapped;

	// Proposed register contents, reserved bits forced to zero
	assign new_pin  = pin_control_s'(wbyte & PIN_MASK);
	assign new_baud = baud_s'(wbyte & BAUD_MASK);
	assign new_ctrl = ctrl_s'(wbyte & CTRL_MASK);

	// Mode and pin-derived terms
	assign master  = ctrl.enable && ctrl.master_select;
	assign sel_low = !settled[3];
	assign fault_evt = master && pin_ctl.fault_detect_enable
		&& !ctrl.select_output_enable && sel_low;
	assign halted  = pin_ctl.stop_in_wait && wait_mode;
	assign slave_act = ctrl.enable && !ctrl.master_select
		&& sel_low;
	assign sck_rise = settled[2] && !sck_prev;
	assign sck_fall = !settled[2] && sck_prev;
	assign start   = wr && idx == IDX_DATA && master && state == ST_IDLE
		&& rise_dly == '0;

	// Master strobes; a received bit lands after the pin latency
	assign master_rise = state == ST_SHIFT && ctrl.master_select
		&& !halted && div_cnt == '0 && !sck_level;
	assign master_done = ctrl.master_select && rise_dly[SAMPLE_LAG-1]
		&& rx_cnt == LAST_BIT;
	assign slave_done  = state == ST_SHIFT && !ctrl.master_select
		&& sck_fall && edge_cnt == LAST_BIT;

	// Settings whose change kills a master transfer
	always_comb begin
		cfg_abort = 1'b0;
		if (wr && master) begin
			unique case (idx)
				IDX_PIN: begin
					cfg_abort = new_pin.fault_detect_enable
						!= pin_ctl.fault_detect_enable
						|| new_pin.bidir_pin_select
						!= pin_ctl.bidir_pin_select;
					if (pin_ctl.bidir_pin_select
						&& new_pin.bidir_output_enable
						!= pin_ctl.bidir_output_enable) begin
						cfg_abort = 1'b1;
					end
				end
				IDX_BAUD: cfg_abort = new_baud != baud;
				IDX_CTRL: cfg_abort = new_ctrl != ctrl;
				default: cfg_abort = 1'b0;
			endcase
		end
	end
	// Swapping master and slave forces idle as well
	assign mode_flip = wr && idx == IDX_CTRL
		&& new_ctrl.master_select != ctrl.master_select;
	assign abort = cfg_abort || fault_evt || mode_flip;

	// Serial input pin follows mode and pin configuration
	always_comb begin
		if (ctrl.master_select) begin
			rx_bit = pin_ctl.bidir_pin_select
				? settled[1] : settled[0];
		end else begin
			rx_bit = pin_ctl.bidir_pin_select
				? settled[0] : settled[1];
		end
	end

	// Three-stage pin synchronisers: select, sck, mosi, miso
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync <= {3{PIN_IDLE}}; // No false select edge after reset
		end else begin
			sync <= {sync[1:0], {select_in, sck_in, mosi_in, miso_in}};
		end
	end

	// Settled pin levels; select idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settled  <= PIN_IDLE;
			sck_prev <= 1'b0;
		end else begin
			settled  <= settle(sync[1], sync[2], settled);
			sck_prev <= settled[2];
		end
	end

	// Control register; a mode fault drops back to slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= ctrl_s'(CTRL_RESET);
		end else if (fault_evt) begin
			ctrl.master_select <= 1'b0;
		end else if (wr && idx == IDX_CTRL) begin
			ctrl <= new_ctrl;
		end
	end

	// Pin control and baud registers, writable anytime
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_ctl <= pin_control_s'(PIN_RESET);
			baud    <= baud_s'(BAUD_RESET);
		end else if (wr) begin
			if (idx == IDX_PIN) begin
				pin_ctl <= new_pin;
			end
			if (idx == IDX_BAUD) begin
				baud <= new_baud;
			end
		end
	end

	// Fault flag: status read arms, control write clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_flag  <= 1'b0;
			fault_armed <= 1'b0;
		end else begin
			if (rd && idx == IDX_STAT && fault_flag) begin
				fault_armed <= 1'b1;
			end else if (wr && idx == IDX_CTRL) begin
				fault_armed <= 1'b0;
			end
			if (fault_evt) begin
				fault_flag <= 1'b1;
			end else if (wr && idx == IDX_CTRL && fault_armed) begin
				fault_flag <= 1'b0;
			end
		end
	end

	// Transfer state: master runs on its own clock, slave on select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
		end else if (abort || !ctrl.enable) begin
			state <= ST_IDLE;
		end else if (ctrl.master_select) begin
			if (start) begin
				state <= ST_SHIFT;
			end else if (state == ST_SHIFT && !halted && div_cnt == '0
				&& edge_cnt == LAST_EDGE) begin
				state <= ST_IDLE;
			end
		end else begin
			state <= slave_act ? ST_SHIFT : ST_IDLE;
		end
	end

	// Baud counter and master serial clock level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt   <= '0;
			sck_level <= 1'b0;
		end else if (abort || start || state == ST_IDLE) begin
			div_cnt   <= half_period(baud) - 11'h001;
			sck_level <= 1'b0;
		end else if (ctrl.master_select && !halted) begin
			if (div_cnt == '0) begin
				div_cnt   <= half_period(baud) - 11'h001;
				sck_level <= !sck_level;
			end else begin
				div_cnt <= div_cnt - 11'h001;
			end
		end
	end

	// Shifter: master shifts out on falls, slave samples on rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shifter  <= '0;
			sample   <= 1'b0;
			edge_cnt <= '0;
		end else if (abort || state == ST_IDLE) begin
			edge_cnt <= '0;
			if (wr && idx == IDX_DATA) begin
				shifter <= wbyte;
			end
		end else if (ctrl.master_select) begin
			if (!halted && div_cnt == '0) begin
				edge_cnt <= edge_cnt + 4'h1;
				if (sck_level) begin
					shifter <= {shifter[6:0], 1'b0};
				end
			end
		end else if (sck_rise) begin
			sample <= rx_bit;
		end else if (sck_fall) begin
			shifter  <= {shifter[6:0], sample};
			edge_cnt <= (edge_cnt == LAST_BIT) ? 4'h0
				: edge_cnt + 4'h1;
		end
	end

	// Rising-edge strobes delayed by the synchroniser latency, so that
	// the bit seen at the pin at each rise is caught even at divide-by-two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_dly <= '0;
		end else if (abort || !ctrl.enable) begin
			rise_dly <= '0;
		end else begin
			rise_dly <= {rise_dly[SAMPLE_LAG-2:0], master_rise};
		end
	end

	// Master receive register and bit count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_shift <= '0;
			rx_cnt   <= '0;
		end else if (start) begin
			rx_cnt <= '0;
		end else if (rise_dly[SAMPLE_LAG-1]) begin
			rx_shift <= {rx_shift[6:0], rx_bit};
			rx_cnt   <= rx_cnt + 4'h1;
		end
	end

	// Received byte and completion flag; completion beats a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data   <= '0;
			done_flag <= 1'b0;
		end else if (!abort && master_done) begin
			rx_data   <= {rx_shift[6:0], rx_bit};
			done_flag <= 1'b1;
		end else if (!abort && slave_done) begin
			rx_data   <= {shifter[6:0], sample};
			done_flag <= 1'b1;
		end else if (rd && idx == IDX_DATA) begin
			done_flag <= 1'b0;
		end
	end

	// Read multiplexer
	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			IDX_CTRL: rd_byte = ctrl;
			IDX_PIN:  rd_byte = pin_ctl;
			IDX_BAUD: rd_byte = baud;
			IDX_STAT: begin
				rd_byte[STAT_DONE]  = done_flag;
				rd_byte[STAT_FAULT] = fault_flag;
				rd_byte[STAT_BUSY]  = state == ST_SHIFT
					|| rise_dly != '0;
			end
			IDX_DATA: rd_byte = rx_data;
			default:  rd_byte = 8'h00;
		endcase
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup && !pwrite) begin
			prdata <= mapped ? {24'h000000, rd_byte} : '0;
		end
	end

	// Serial clock pin: driven only by an enabled master
	assign sck_out.level = sck_level;
	assign sck_out.oe_n  = !master;

	// MOSI: master output unless bidir with buffer off
	assign mosi_out.level = shifter[7];
	assign mosi_out.oe_n  = !(master && (!pin_ctl.bidir_pin_select
		|| pin_ctl.bidir_output_enable));

	// MISO: selected slave output unless bidir with buffer off
	assign miso_out.level = shifter[7];
	assign miso_out.oe_n  = !(slave_act && (!pin_ctl.bidir_pin_select
		|| pin_ctl.bidir_output_enable));

	// Select pin: low during a master transfer when configured as output
	assign select_out.level = state != ST_SHIFT;
	assign select_out.oe_n  = !(master && pin_ctl.fault_detect_enable
		&& ctrl.select_output_enable);

endmodule

// ### src/spi_pin_pkg.sv
// Constants, register layouts and types for the SPI pin and baud block.
// Assumes a 32-bit APB slave port and one 25 MHz bus clock.
package spi_pin_pkg;

	// APB widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_PIN  = 3'h1;
	localparam logic [2:0] IDX_BAUD = 3'h2;
	localparam logic [2:0] IDX_STAT = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h5;

	// Writable bits and reset values
	localparam logic [7:0] CTRL_MASK  = 8'h52;
	localparam logic [7:0] PIN_MASK   = 8'h1B;
	localparam logic [7:0] BAUD_MASK  = 8'h77;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PIN_RESET  = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;

	// Status bit positions
	localparam int STAT_DONE  = 7;
	localparam int STAT_FAULT = 4;
	localparam int STAT_BUSY  = 0;

	// Transfer framing
	localparam logic [3:0] LAST_EDGE  = 4'hF;
	localparam logic [3:0] LAST_BIT   = 4'h7;
	localparam int         HALF_W     = 11;
	localparam int         SAMPLE_LAG = 4;

	// Pin levels while nothing drives them; select idles high
	localparam logic [3:0] PIN_IDLE   = 4'h8;

	typedef struct packed {
		logic       rsv7;
		logic       enable;
		logic       rsv5;
		logic       master_select;
		logic [1:0] rsv3;
		logic       select_output_enable;
		logic       rsv0;
	} ctrl_s;

	typedef struct packed {
		logic [2:0] rsv7;
		logic       fault_detect_enable;
		logic       bidir_output_enable;
		logic       rsv2;
		logic       stop_in_wait;
		logic       bidir_pin_select;
	} pin_control_s;

	typedef struct packed {
		logic       rsv7;
		logic [2:0] baud_preselect;
		logic       rsv3;
		logic [2:0] baud_exponent;
	} baud_s;

	// Output half of a two-way pin
	typedef struct packed {
		logic level;
		logic oe_n;
	} pin_out_s;

	typedef enum logic {
		ST_IDLE  = 1'b0,
		ST_SHIFT = 1'b1
	} xfer_e;

endpackage

// ### test/spi_pin_baud_assertions.sv
// Checker for the SPI pin and baud block, top-level ports only.
// Assumes APB on pclk; register shadows are built from bus writes.
`timescale 1ns/1ps
module spi_pin_baud_assertions (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [spi_pin_pkg::ADDR_W-1:0] paddr,
	input wire logic [spi_pin_pkg::DATA_W-1:0] pwdata,
	input wire logic [spi_pin_pkg::DATA_W-1:0] prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire logic                         wait_mode,
	input wire logic                         sck_in,
	input wire spi_pin_pkg::pin_out_s        sck_out,
	input wire logic                         mosi_in,
	input wire spi_pin_pkg::pin_out_s        mosi_out,
	input wire logic                         miso_in,
	input wire spi_pin_pkg::pin_out_s        miso_out,
	input wire logic                         select_in,
	input wire spi_pin_pkg::pin_out_s        select_out
);
	import spi_pin_pkg::*;
	logic [7:0]  pin;
	logic [7:0]  baud;
	logic        ms;
	logic        last;
	logic        prev_in;
	logic [10:0] gap;
	wire         wr = psel && penable && pwrite;
	wire         chg = last != sck_out.level;
	wire  [10:0] h = ({8'h0, baud[6:4]} + 11'h1) << baud[2:0];

	// Register shadows from completed writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= 8'h00;
			baud <= 8'h00;
			ms <= 1'b0;
		end else if (wr) begin
			if (paddr == 8'h04) pin <= pwdata[7:0] & PIN_MASK;
			if (paddr == 8'h08) baud <= pwdata[7:0] & BAUD_MASK;
			if (paddr == 8'h00) ms <= pwdata[4];
		end
	end

	// Cycles since the serial clock last moved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 1'b0;
			gap <= 11'h0;
			prev_in <= 1'b0;
		end else begin
			last <= sck_out.level;
			gap <= chg ? 11'h0 : gap + 11'h1;
			if (select_out.level || wait_mode) prev_in <= 1'b0;
			else if (chg) prev_in <= 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_access: assert property (pready == (psel && penable))
		else $error("ready not tied to access phase");
	a_unmapped_err: assert property (
		psel && penable && paddr == 8'h10 |-> pslverr)
		else $error("unmapped access without error");
	a_reserved_zero: assert property (
		psel && penable && !pwrite && paddr == 8'h04
		|-> (prdata & ~32'h1B) == 32'h0)
		else $error("reserved pin bits read nonzero");
	a_sel_unused: assert property (ms && !pin[4] |-> select_out.oe_n)
		else $error("select driven with detection off");
	a_sel_input: assert property (!ms |-> select_out.oe_n)
		else $error("slave drives select");
	a_miso_unused: assert property (ms && pin[0] |-> miso_out.oe_n)
		else $error("master bidir drives miso");
	a_mosi_unused: assert property (!ms && pin[0] |-> mosi_out.oe_n)
		else $error("slave bidir drives mosi");
	a_half_period: assert property (
		chg && prev_in && !select_out.level && !wait_mode
		|-> gap == h - 11'h1)
		else $error("serial clock half period wrong");
	a_wait_freeze: assert property (
		wait_mode && pin[1] |=> $stable(sck_out.level))
		else $error("serial clock moved in wait");
	a_abort_idle: assert property (
		wr && ms && ((paddr == 8'h08 && (pwdata[7:0] & 8'h77) != baud)
		|| (paddr == 8'h04 && ((pwdata[7:0] ^ pin)
		& {4'h1, pin[0], 3'h1}) != 8'h0)) |-> ##[1:2] select_out.level)
		else $error("setting change did not abort");
	a_sck_idle: assert property (
		ms && select_out.level && $past(select_out.level)
		|-> !sck_out.level)
		else $error("serial clock high while idle");

	c_transfer: cover property ($fell(select_out.level));
	c_abort: cover property (wr && ms && paddr == 8'h08 && !select_out.level);
	c_freeze: cover property (wait_mode && pin[1] && !select_out.level);
endmodule

// ### test/spi_far_end.sv
// Far-side SPI slave model, clock idle low, MSB first.
// Assumes the bench resolves select, clock and data pins.
`timescale 1ns/1ps
module spi_far_end (
	input  wire logic       sck,
	input  wire logic       ss_n,
	input  wire logic       mosi,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic [7:0]      rx
);
	logic [7:0] sh;
	initial miso = 1'b1;
	// Load and present the first bit when selected
	always @(negedge ss_n) begin
		sh = tx;
		miso = tx[7];
	end
	// Sample on rise, shift out on fall
	always @(posedge sck) if (!ss_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!ss_n) begin
		sh = sh << 1;
		miso = sh[7];
	end
	// Released line shows the inverse of its last value
	always @(posedge ss_n) miso = ~miso;
endmodule

// ### test/tb.sv
// Self-checking bench for the SPI pin and baud block.
// Assumes the far-side model and checker are compiled first.
`timescale 1ns/1ps
module tb;
	import spi_pin_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        wait_mode = 0, ss_drv = 1, pready, pslverr, fmiso, slverr, s;
	logic [7:0]  paddr = 0, ptx = 0, prx, r, d;
	logic [31:0] pwdata = 0, prdata;
	logic [3:0]  e, pins;
	pin_out_s    sck_out, mosi_out, miso_out, select_out;
	int          errors = 0, n_checks = 0, seed = 32'hd516, h, hi = 0, hi0, i;
	// Only the block as master clocks the link; the block as slave is never clocked here
	wire         sck_w = sck_out.level & ~sck_out.oe_n;
	wire         ss_w = select_out.oe_n ? ss_drv : select_out.level;
	wire         mosi_w = mosi_out.level ^ mosi_out.oe_n;
	wire         miso_w = miso_out.oe_n ? fmiso : miso_out.level;

	always #20 pclk = ~pclk;
	// Count bus cycles with the serial clock high
	always @(posedge pclk) hi <= hi + sck_out.level;

	spi_pin_baud u_spi_pin_baud(.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .wait_mode,
		.sck_in(sck_w), .sck_out, .mosi_in(mosi_w), .mosi_out,
		.miso_in(miso_w), .miso_out, .select_in(ss_w), .select_out);
	spi_far_end u_spi_far_end(.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w),
		.tx(ptx), .miso(fmiso), .rx(prx));

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask

	// One APB transfer, held until pready at the sampling edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] v);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata[7:0];
		slverr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Start a master transfer at divider setting b
	task automatic go(input logic [7:0] b);
		apb(1, 8'h08, b);
		h = (b[6:4] + 32'd1) << b[2:0];
		ptx = $random(seed);
		d = $random(seed);
		hi0 = hi;
		apb(1, 8'h14, d);
	endtask

	// Wait for the end, then compare both bytes and clock length
	task automatic fin(input bit timed);
		do apb(0, 8'h0C, 0); while (r[0]);
		chk(r[7], 1);
		if (timed) chk(hi - hi0, 8 * h);
		apb(0, 8'h14, 0);
		chk(r, ptx);
		chk(prx, d);
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		// Reset values, write masks and an unmapped place
		apb(0, 8'h04, 0);
		chk(r, 0);
		apb(0, 8'h08, 0);
		chk(r, 0);
		apb(1, 8'h04, 8'hFF);
		apb(0, 8'h04, 0);
		chk(r, 8'h1B);
		apb(1, 8'h08, 8'hFF);
		apb(0, 8'h08, 0);
		chk(r, 8'h77);
		apb(0, 8'h10, 0);
		chk(slverr, 1);
		$display("test registers done");
		// Pin drive for each mode and pin setting
		for (i = 0; i < 8; i++) begin
			ss_drv <= i[2];
			apb(1, 8'h00, i[2] ? 8'h50 : 8'h40);
			apb(1, 8'h04, {4'h0, i[1], 2'h0, i[0]});
			repeat (4) @(posedge pclk);
			e = {!(i[2] && (!i[0] || i[1])),
				!(!i[2] && (!i[0] || i[1])), 1'b1, !i[2]};
			pins = {mosi_out.oe_n, miso_out.oe_n, select_out.oe_n,
				sck_out.oe_n};
			chk(pins, e);
		end
		$display("test pins done");
		// Master transfers over boundary and random dividers
		ss_drv <= 1;
		apb(1, 8'h00, 8'h52);
		apb(1, 8'h04, 8'h10);
		@(posedge pclk);
		chk(select_out.oe_n, 0);
		for (i = 0; i < 4; i++) begin
			wait_mode <= $random(seed);
			go(i == 0 ? 8'h00 : i == 1 ? 8'h77 : $random(seed) & 8'h33);
			fin(1);
		end
		$display("test transfers done");
		// Clock frozen in wait with stop set
		wait_mode <= 0;
		apb(1, 8'h04, 8'h12);
		go(8'h03);
		repeat (20) @(posedge pclk);
		wait_mode <= 1;
		repeat (2) @(posedge pclk);
		s = sck_out.level;
		repeat (40) @(posedge pclk);
		chk(sck_out.level, s);
		wait_mode <= 0;
		fin(0);
		$display("test wait done");
		// Mid-transfer setting changes force idle
		for (i = 0; i < 2; i++) begin
			apb(1, 8'h04, 8'h11);
			go(8'h77);
			repeat (30) @(posedge pclk);
			apb(1, i ? 8'h04 : 8'h08, i ? 8'h19 : 8'h76);
			apb(0, 8'h0C, 0);
			chk(r & 8'h81, 0);
		end
		$display("test abort done");
		// Select pulled low under a master with detection on
		apb(1, 8'h04, 8'h10);
		apb(1, 8'h00, 8'h50);
		ss_drv <= 0;
		repeat (6) @(posedge pclk);
		apb(0, 8'h0C, 0);
		chk(r[4], 1);
		apb(0, 8'h00, 0);
		chk(r, 8'h40);
		$display("test fault done");
		complete_run;
	end

	// Watchdog against a hung handshake
	initial begin
		#2000000;
		errors++;
		complete_run;
	end
endmodule

bind spi_pin_baud spi_pin_baud_assertions u_spi_pin_baud_assertions(.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .wait_mode, .sck_in, .sck_out, .mosi_in, .mosi_out, .miso_in,
	.miso_out, .select_in, .select_out);
